//--- rtl/mac_fifo_regs_pkg.sv
package mac_fifo_regs_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Register indices as printed, byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h10;
    localparam logic [7:0] IDX_INTEN = 8'h12;
    localparam logic [7:0] IDX_STATUS = 8'h13;
    localparam logic [7:0] IDX_SWRST = 8'h14;
    localparam logic [7:0] IDX_CLEAR = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_INTEN = {IDX_INTEN[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SWRST = {IDX_SWRST[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = {IDX_CLEAR[5:0], 2'h0};

    // Control register fields and hardware reset value
    localparam int BIT_PASS_ODD = 6;
    localparam int BIT_RXCLK_ON = 3;
    localparam logic [REG_W-1:0] CTRL_RESET = 16'h4448;

    // Interrupt enable and status field positions
    localparam int BIT_FIFO_ERR = 7;
    localparam int BIT_IDLE_INS = 3;
    localparam int BIT_IDLE_DEL = 2;
    localparam logic [REG_W-1:0] INTEN_RESET = 16'h0000;

    // Software reset command bit
    localparam int BIT_SWRST_GO = 0;

    // Number of latched event flags
    localparam int NUM_EVT = 3;

    // Copper elastic FIFO event inputs
    typedef struct packed {
        logic fifo_err;
        logic idle_ins;
        logic idle_del;
    } fifo_events_t;

    // State of the register group except the latched flags
    typedef struct packed {
        logic [REG_W-1:0] ctrl;
        logic pass_odd_live;
        logic rxclk_on_live;
        logic [REG_W-1:0] inten;
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
        logic irq;
    } regs_state_t;

    // State of one latched flag
    typedef struct packed {
        logic q;
    } flag_state_t;

endpackage

//--- rtl/sticky_flag.sv
`timescale 1ns/1ns
module sticky_flag
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Set and clear requests
    input wire logic set,
    input wire logic clr,
    // Latched value
    output logic q
);

    // Current and next state
    mac_fifo_regs_pkg::flag_state_t st;
    mac_fifo_regs_pkg::flag_state_t next_st;

    // Set beats clear so an event in the clear cycle survives
    always_comb
    begin
        next_st.q = set | (st.q & ~clr);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule // sticky_flag

//--- rtl/mac_side_fifo_ctrl_status.sv
// Notes on behaviour
// - Preamble bit 0 pads, 1 passes; reset 1
// - Control changes take effect at software reset
// - Receive clock control 1 keeps clock running
// - Three interrupt enables, bits 7,3,2, reset 0
// - FIFO over/underflow latches status bit 7
// - Idle insertion latches status bit 3
// - Idle deletion latches status bit 2
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module mac_side_fifo_ctrl_status
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mac_fifo_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [mac_fifo_regs_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [mac_fifo_regs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Copper FIFO events
    input wire mac_fifo_regs_pkg::fifo_events_t events,
    // Controls in effect
    output logic pass_odd_preamble,
    output logic rx_clk_always_on,
    // Interrupt
    output logic irq
);

    // Register state and its next value
    mac_fifo_regs_pkg::regs_state_t st;
    mac_fifo_regs_pkg::regs_state_t next_st;

    // Latched flags: [2] FIFO error, [1] idle inserted, [0] idle deleted
    logic [mac_fifo_regs_pkg::NUM_EVT-1:0] stat;
    logic [mac_fifo_regs_pkg::NUM_EVT-1:0] stat_set;
    logic [mac_fifo_regs_pkg::NUM_EVT-1:0] stat_clr;
    // Enables in the same bit order as the flags
    logic [mac_fifo_regs_pkg::NUM_EVT-1:0] en_vec;
    // Status as it reads on the bus
    logic [mac_fifo_regs_pkg::REG_W-1:0] stat_word;

    // Bus phase decode
    logic access;
    logic done;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic swrst;
    logic [mac_fifo_regs_pkg::REG_W-1:0] wmask;
    logic [mac_fifo_regs_pkg::REG_W-1:0] clear_word;

    // Transfer completes at the edge where pready is seen high
    // One fixed wait state keeps read data a registered snapshot, which the
    // read-clear logic relies on; errored transfers neither write nor clear
    assign access = psel & penable;
    assign done = access & st.pready;
    assign wr_done = done & pwrite & ~st.pslverr;
    assign rd_done = done & ~pwrite & ~st.pslverr;

    // Known addresses; anything else answers with pslverr
    // Holes answer with an error so a mistyped address shows up at the host
    assign mapped = (paddr == mac_fifo_regs_pkg::ADDR_CTRL)
        | (paddr == mac_fifo_regs_pkg::ADDR_INTEN)
        | (paddr == mac_fifo_regs_pkg::ADDR_STATUS)
        | (paddr == mac_fifo_regs_pkg::ADDR_SWRST)
        | (paddr == mac_fifo_regs_pkg::ADDR_CLEAR);

    // Byte lanes for the 16-bit registers
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Software reset command, self clearing
    assign swrst = wr_done & (paddr == mac_fifo_regs_pkg::ADDR_SWRST)
        & pstrb[0] & pwdata[mac_fifo_regs_pkg::BIT_SWRST_GO];

    // Write-one-to-clear word, only when that register is hit
    // Lanes left unstrobed clear nothing
    assign clear_word = (wr_done && paddr == mac_fifo_regs_pkg::ADDR_CLEAR)
        ? (pwdata[15:0] & wmask) : 16'h0000;

    // Event inputs straight onto the flag set terms
    assign stat_set = {events.fifo_err, events.idle_ins, events.idle_del};

    // Clear only what the read actually returned, so a later event is kept
    // Hazard: clearing from the live flags would lose an event that lands
    // between the data snapshot and the completing edge
    always_comb
    begin
        stat_clr[2] = swrst | clear_word[mac_fifo_regs_pkg::BIT_FIFO_ERR]
            | (rd_done & (paddr == mac_fifo_regs_pkg::ADDR_STATUS)
            & st.prdata[mac_fifo_regs_pkg::BIT_FIFO_ERR]);
        stat_clr[1] = swrst | clear_word[mac_fifo_regs_pkg::BIT_IDLE_INS]
            | (rd_done & (paddr == mac_fifo_regs_pkg::ADDR_STATUS)
            & st.prdata[mac_fifo_regs_pkg::BIT_IDLE_INS]);
        stat_clr[0] = swrst | clear_word[mac_fifo_regs_pkg::BIT_IDLE_DEL]
            | (rd_done & (paddr == mac_fifo_regs_pkg::ADDR_STATUS)
            & st.prdata[mac_fifo_regs_pkg::BIT_IDLE_DEL]);
    end

    // One latched flag per event
    // Set-wins lives in one small module so the three flags cannot drift apart
    genvar gi;
    generate
        for (gi = 0; gi < mac_fifo_regs_pkg::NUM_EVT; gi++)
        begin : g_flag
            sticky_flag u_flag
            (
                .pclk(pclk),
                .presetn(presetn),
                .set(stat_set[gi]),
                .clr(stat_clr[gi]),
                .q(stat[gi])
            );
        end
    endgenerate

    // Flags placed at their bit positions, reserved bits read zero
    always_comb
    begin
        stat_word = 16'h0000;
        stat_word[mac_fifo_regs_pkg::BIT_FIFO_ERR] = stat[2];
        stat_word[mac_fifo_regs_pkg::BIT_IDLE_INS] = stat[1];
        stat_word[mac_fifo_regs_pkg::BIT_IDLE_DEL] = stat[0];
    end

    // Enable bits lined up with the flags
    assign en_vec = {st.inten[mac_fifo_regs_pkg::BIT_FIFO_ERR],
        st.inten[mac_fifo_regs_pkg::BIT_IDLE_INS],
        st.inten[mac_fifo_regs_pkg::BIT_IDLE_DEL]};

    // Next state of registers, bus answer and controls
    always_comb
    begin
        next_st = st;
        next_st.pready = 1'b0;
        // Wait state: answer one cycle into the access phase
        // Address and direction come from the held request, never latched
        if (access && !st.pready)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = ~mapped;
            next_st.prdata = '0;
            if (!pwrite)
            begin
                case (paddr)
                    mac_fifo_regs_pkg::ADDR_CTRL:
                    begin
                        next_st.prdata[15:0] = st.ctrl;
                    end
                    mac_fifo_regs_pkg::ADDR_INTEN:
                    begin
                        next_st.prdata[15:0] = st.inten;
                    end
                    mac_fifo_regs_pkg::ADDR_STATUS:
                    begin
                        // Snapshot decides which bits the read clears
                        next_st.prdata[15:0] = stat_word;
                    end
                    default:
                    begin
                        // Command registers and holes read zero
                        next_st.prdata = '0;
                    end
                endcase
            end
        end
        else if (done)
        begin
            next_st.pslverr = 1'b0;
        end
        // Stored control bits change at once, the live copy does not
        if (wr_done && paddr == mac_fifo_regs_pkg::ADDR_CTRL)
        begin
            // Reserved fields are simply stored; host keeps them at reset value
            next_st.ctrl = (st.ctrl & ~wmask) | (pwdata[15:0] & wmask);
        end
        // All enable bits are storage, reserved ones included
        if (wr_done && paddr == mac_fifo_regs_pkg::ADDR_INTEN)
        begin
            next_st.inten = (st.inten & ~wmask) | (pwdata[15:0] & wmask);
        end
        // Disruptive controls go live only on a software reset
        // Stored controls and enables keep their values; the flags clear elsewhere
        if (swrst)
        begin
            next_st.pass_odd_live = st.ctrl[mac_fifo_regs_pkg::BIT_PASS_ODD];
            next_st.rxclk_on_live = st.ctrl[mac_fifo_regs_pkg::BIT_RXCLK_ON];
        end
        // Level interrupt from enabled latched flags
        // Registered so the pin cannot glitch while a flag and its enable move
        next_st.irq = |(stat & en_vec);
    end

    // State register, hardware reset loads documented values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Hardware reset loads the power-up control value; software reset does not
            st.ctrl <= mac_fifo_regs_pkg::CTRL_RESET;
            st.pass_odd_live <= 1'b1;
            st.rxclk_on_live <= 1'b1;
            st.inten <= mac_fifo_regs_pkg::INTEN_RESET;
            st.pready <= 1'b0;
            st.prdata <= '0;
            st.pslverr <= 1'b0;
            st.irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    // Nothing combinational reaches a pin, so boundary timing stays simple
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign pass_odd_preamble = st.pass_odd_live;
    assign rx_clk_always_on = st.rxclk_on_live;
    assign irq = st.irq;

    // Checks on the block's own behaviour
    // Flag checks mostly need quiet events, since a set would mask a clear
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Live preamble control follows the stored bit after software reset
    pass_odd_load_a: assert property (swrst |=> pass_odd_preamble
        == $past(st.ctrl[mac_fifo_regs_pkg::BIT_PASS_ODD]))
        else $error("preamble control not loaded on software reset");

    // A control write alone leaves the live controls untouched
    ctrl_hold_a: assert property (!swrst |=> $stable(pass_odd_preamble)
        && $stable(rx_clk_always_on))
        else $error("live control changed without software reset");

    // Receive clock control follows the stored bit after software reset
    rxclk_load_a: assert property (swrst |=> rx_clk_always_on
        == $past(st.ctrl[mac_fifo_regs_pkg::BIT_RXCLK_ON]))
        else $error("rx clock control not loaded on software reset");

    // Full-width enable write lands in the enable register
    inten_write_a: assert property ((wr_done && pstrb == 4'hF
        && paddr == mac_fifo_regs_pkg::ADDR_INTEN) |=> st.inten == $past(pwdata[15:0]))
        else $error("interrupt enable write lost");

    // FIFO error latches and is visible on the next cycle
    fifo_err_latch_a: assert property (events.fifo_err |=> stat[2])
        else $error("FIFO error flag not set");

    // Idle insertion latches
    idle_ins_latch_a: assert property (events.idle_ins |=> stat[1])
        else $error("idle inserted flag not set");

    // Idle deleted flag holds until a clear term reaches it
    idle_del_latch_a: assert property ((stat[0] && !stat_clr[0]) |=> stat[0])
        else $error("idle deleted flag dropped without clear");

    // Interrupt tracks enabled flags one cycle later
    irq_follow_a: assert property (irq == $past(|(stat & en_vec)))
        else $error("interrupt output does not match enabled flags");

    // Status read clears a reported FIFO error bit whose cause has gone
    read_clear_a: assert property ((rd_done && paddr == mac_fifo_regs_pkg::ADDR_STATUS
        && st.prdata[mac_fifo_regs_pkg::BIT_FIFO_ERR] && !events.fifo_err) |=> !stat[2])
        else $error("FIFO error flag not cleared by status read");

    // Idle inserted flag clears on a read that returned it
    read_clear_ins_a: assert property ((rd_done
        && paddr == mac_fifo_regs_pkg::ADDR_STATUS
        && st.prdata[mac_fifo_regs_pkg::BIT_IDLE_INS] && !events.idle_ins) |=> !stat[1])
        else $error("idle inserted flag not cleared by status read");

    // Idle deleted flag clears on a read that returned it
    read_clear_del_a: assert property ((rd_done
        && paddr == mac_fifo_regs_pkg::ADDR_STATUS
        && st.prdata[mac_fifo_regs_pkg::BIT_IDLE_DEL] && !events.idle_del) |=> !stat[0])
        else $error("idle deleted flag not cleared by status read");

    // Status read returns the flags as they stood in the cycle before
    status_snap_a: assert property ((rd_done
        && paddr == mac_fifo_regs_pkg::ADDR_STATUS) |-> prdata[15:0] == $past(stat_word))
        else $error("status read does not match latched flags");

    // FIFO error flag holds until a clear term reaches it
    fifo_err_hold_a: assert property ((stat[2] && !stat_clr[2]) |=> stat[2])
        else $error("FIFO error flag dropped without clear");

    // Idle inserted flag holds until a clear term reaches it
    idle_ins_hold_a: assert property ((stat[1] && !stat_clr[1]) |=> stat[1])
        else $error("idle inserted flag dropped without clear");

    // Idle deletion sets its flag on the next cycle
    idle_del_set_a: assert property (events.idle_del |=> stat[0])
        else $error("idle deleted flag not set");

    // No flag rises in a cycle without its event
    no_false_set_a: assert property ((stat_set == 3'h0)
        |=> ((stat & ~$past(stat)) == 3'h0))
        else $error("status flag set without an event");

    // Software reset empties every flag whose event is quiet
    swrst_clear_a: assert property ((swrst && stat_set == 3'h0)
        |=> (stat == 3'h0))
        else $error("status flags survived a software reset");

    // A write to the status register changes no flag
    status_ro_a: assert property ((wr_done && stat_set == 3'h0
        && paddr == mac_fifo_regs_pkg::ADDR_STATUS) |=> stat == $past(stat))
        else $error("status flags changed by a write");

    // Software reset keeps the stored controls and the enables
    ctrl_keep_a: assert property (swrst |=> $stable(st.ctrl) && $stable(st.inten))
        else $error("stored register changed on software reset");

    // Full-width control write lands in storage but not yet in effect
    ctrl_write_a: assert property ((wr_done && pstrb == 4'hF
        && paddr == mac_fifo_regs_pkg::ADDR_CTRL) |=> st.ctrl == $past(pwdata[15:0]))
        else $error("control write lost");

    // Interrupt stays low while every enable is off
    irq_masked_a: assert property ((en_vec == 3'h0) |=> !irq)
        else $error("interrupt raised with all enables off");

    // An enabled latched flag raises the interrupt on the next cycle
    irq_raise_a: assert property ((stat & en_vec) != 3'h0 |=> irq)
        else $error("interrupt missing for an enabled flag");

    // Main scenarios
    status_read_c: cover property (rd_done && paddr == mac_fifo_regs_pkg::ADDR_STATUS
        && st.prdata[15:0] != 16'h0000);
    irq_raise_c: cover property (!irq ##1 irq);
    swrst_apply_c: cover property (swrst ##1 !pass_odd_preamble);
    set_during_clear_c: cover property (stat_set[2] && stat_clr[2]);
    unmapped_c: cover property (pready && pslverr);

endmodule // mac_side_fifo_ctrl_status

//--- verification/mgmt_host.sv
`timescale 1ns/1ns
module mgmt_host
(
    // Clock
    input wire logic pclk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [mac_fifo_regs_pkg::ADDR_W-1:0] paddr,
    output logic [mac_fifo_regs_pkg::DATA_W-1:0] pwdata,
    output logic [3:0] pstrb,
    // APB answer
    input wire logic [mac_fifo_regs_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end

    // One transfer; request held until pready is seen high, the wait itself is bounded by the bench
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
        output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // Answer taken at the completing edge only
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Data lines no longer hold the last word once released
        pwdata <= ~data;
    endtask
endmodule // mgmt_host

//--- verification/mac_side_fifo_ctrl_status_tb.sv
`timescale 1ns/1ns
module mac_side_fifo_ctrl_status_tb;
    // Bus and design signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pass_odd, rx_on, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    mac_fifo_regs_pkg::fifo_events_t events = '0;
    // Reference model state and bookkeeping
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int flags = 0;
    int en = 0;
    int ev;

    mac_side_fifo_ctrl_status uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
        .pass_odd_preamble(pass_odd), .rx_clk_always_on(rx_on), .irq(irq));
    mgmt_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // Register access with error flag check
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic bad, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        host.xfer(wr, a, d, r, e);
        chk("pslverr", {31'h0, bad}, {31'h0, e});
        if (!wr)
            chk("prdata", exp, r);
    endtask

    // Event flags to status layout
    function automatic logic [31:0] lay(input int f);
        return {24'h0, f[2], 3'h0, f[1], f[0], 2'h0};
    endfunction

    // Settled outputs against the model
    task automatic outs(input logic po, input logic ro);
        @(posedge pclk);
        @(posedge pclk);
        #1;
        chk("pass_odd_preamble", {31'h0, po}, {31'h0, pass_odd});
        chk("rx_clk_always_on", {31'h0, ro}, {31'h0, rx_on});
        chk("irq", {31'h0, 1'b0 | ((flags & en) != 0)}, {31'h0, irq});
    endtask

    // One event pulse, folded into the model
    task automatic pulse(input int v);
        @(posedge pclk);
        events <= mac_fifo_regs_pkg::fifo_events_t'(v[2:0]);
        @(posedge pclk);
        events <= '0;
        flags = flags | v;
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        void'($urandom(26));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Hardware reset values
        outs(1'b1, 1'b1);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h00004448);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_INTEN, 32'h0, 1'b0, 32'h0);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0);
        $display("test reset done");
        // Controls change only at software reset; reserved bits kept at reset values
        acc(1'b1, mac_fifo_regs_pkg::ADDR_CTRL, 32'h00004400, 1'b0, 32'h0);
        outs(1'b1, 1'b1);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_SWRST, 32'h1, 1'b0, 32'h0);
        outs(1'b0, 1'b0);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_CTRL, 32'h00004448, 1'b0, 32'h0);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_SWRST, 32'h1, 1'b0, 32'h0);
        outs(1'b1, 1'b1);
        $display("test controls done");
        // Random events, enables and read-clear against the model
        for (int i = 0; i < 24; i++)
        begin
            if (i % 6 == 0)
            begin
                en = $urandom % 8;
                acc(1'b1, mac_fifo_regs_pkg::ADDR_INTEN, lay(en), 1'b0, 32'h0);
                acc(1'b0, mac_fifo_regs_pkg::ADDR_INTEN, 32'h0, 1'b0, lay(en));
            end
            ev = $urandom % 8;
            pulse(ev);
            outs(1'b1, 1'b1);
            if (i % 3 == 2)
            begin
                acc(1'b0, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0, 1'b0, lay(flags));
                flags = 0;
                outs(1'b1, 1'b1);
            end
        end
        $display("test events done");
        // Clear register, status write ignored, unmapped address refused
        en = 7;
        acc(1'b1, mac_fifo_regs_pkg::ADDR_INTEN, 32'h0000008C, 1'b0, 32'h0);
        pulse(7);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0000008C, 1'b0, 32'h0);
        outs(1'b1, 1'b1);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_CLEAR, 32'h00000088, 1'b0, 32'h0);
        flags = 1;
        outs(1'b1, 1'b1);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0, 1'b0, lay(flags));
        flags = 0;
        outs(1'b1, 1'b1);
        pulse(5);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_SWRST, 32'h1, 1'b0, 32'h0);
        flags = 0;
        acc(1'b0, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0);
        // Enables and stored controls survive software reset; hardware reset restores all
        acc(1'b0, mac_fifo_regs_pkg::ADDR_INTEN, 32'h0, 1'b0, 32'h0000008C);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_CTRL, 32'h00004400, 1'b0, 32'h0);
        acc(1'b1, mac_fifo_regs_pkg::ADDR_SWRST, 32'h1, 1'b0, 32'h0);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h00004400);
        pulse(7);
        outs(1'b0, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        flags = 0;
        en = 0;
        outs(1'b1, 1'b1);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_CTRL, 32'h0, 1'b0, 32'h00004448);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_INTEN, 32'h0, 1'b0, 32'h0);
        acc(1'b0, mac_fifo_regs_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0);
        acc(1'b1, 8'h44, 32'hFFFF, 1'b1, 32'h0);
        acc(1'b0, 8'h44, 32'h0, 1'b1, 32'h0);
        $display("test clear and errors done");
        wrap_up();
    end
endmodule // mac_side_fifo_ctrl_status_tb
